// File: verilog/sbp_pkg.sv
// Purpose: shared constants and types for the supply brownout / power-on monitor
// Assumes: 8-bit register port, 100 MHz system clock
// Notes:   offsets are word indices on the plain register port
package sbp_pkg;
  localparam int unsigned DW      = 8;
  localparam int unsigned AW      = 8;
  localparam int unsigned N_TRIP  = 3;
  localparam int unsigned N_EVT   = 4;

  // register offsets
  localparam logic [AW-1:0] ADR_PWR_CTRL = 8'h00; // power_control_reg
  localparam logic [AW-1:0] ADR_INT_EN0  = 8'h01; // int_enable_reg0
  localparam logic [AW-1:0] ADR_BO_CFG   = 8'h02; // brownout_config_reg
  localparam logic [AW-1:0] ADR_RST_SRC  = 8'h03; // reset_source_reg
  localparam logic [AW-1:0] ADR_INT_STAT = 8'h04; // sticky event status, read only
  localparam logic [AW-1:0] ADR_INT_CLR  = 8'h05; // write 1 to clear status
  localparam logic [AW-1:0] ADR_INT_ENA  = 8'h06; // status enable
  localparam logic [AW-1:0] ADR_LIVE     = 8'h07; // live monitor state, read only

  // field positions
  localparam int unsigned PWR_MODE_LSB  = 0;
  localparam int unsigned PWR_BOI_BIT   = 4;
  localparam int unsigned IEN_EBO_BIT   = 5;
  localparam int unsigned IEN_EA_BIT    = 7;
  localparam int unsigned BOCFG_LSB     = 0;
  localparam int unsigned UCFG_HI_BIT   = 5;
  localparam int unsigned UCFG_LO_BIT   = 3;
  localparam int unsigned RSRC_POF_BIT  = 4;
  localparam int unsigned RSRC_BOF_BIT  = 5;
  localparam int unsigned RSRC_BROWNOUT_IRQ_FLAG_BIT = 6;

  // trip vector positions
  localparam int unsigned TRIP_RST   = 0;
  localparam int unsigned TRIP_IRQ   = 1;
  localparam int unsigned TRIP_FLASH = 2;

  // event status positions
  localparam int unsigned EVT_RST   = 0;
  localparam int unsigned EVT_IRQ   = 1;
  localparam int unsigned EVT_FLASH = 2;
  localparam int unsigned EVT_POR   = 3;

  // reset values
  localparam logic [1:0]       MODE_RST    = 2'h0;
  localparam logic [1:0]       BOCFG_RST   = 2'h0;
  localparam logic [N_EVT-1:0] EVT_EN_RST  = 4'h0;

  // trip level indices reported by the decoder
  localparam logic [1:0] RLVL_2V2 = 2'h0;
  localparam logic [1:0] RLVL_2V4 = 2'h1;
  localparam logic [1:0] RLVL_3V0 = 2'h2;
  localparam logic [1:0] ILVL_2V4 = 2'h0;
  localparam logic [1:0] ILVL_2V6 = 2'h1;
  localparam logic [1:0] ILVL_3V2 = 2'h2;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_IDLE   = 2'b01,
    MODE_PDOWN  = 2'b10,
    MODE_TOTAL  = 2'b11
  } sbp_mode_t;

  // gray along reset -> power-on -> run
  typedef enum logic [1:0] {
    ST_RESET   = 2'b00,
    ST_POWERON = 2'b01,
    ST_RUN     = 2'b11
  } sbp_state_t;
endpackage

// File: verilog/sbp_trip_if.sv
// Purpose: carries trip select code and its decoded levels
// Assumes: purely combinational link between control and decoder
// Notes:   none
`timescale 1ns/1ps
interface sbp_trip_if;
  logic [3:0] sel;
  logic       valid;
  logic [1:0] rst_lvl;
  logic [1:0] irq_lvl;
  modport dec (input sel, output valid, output rst_lvl, output irq_lvl);
  modport ctl (output sel, input valid, input rst_lvl, input irq_lvl);
endinterface

// File: verilog/sbp_sync.sv
// Purpose: two-flop synchroniser for the analog trip lines
// Assumes: trip lines change slowly against clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module sbp_sync
  import sbp_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic [sbp_pkg::N_TRIP-1:0] trip_raw,
  output logic      [sbp_pkg::N_TRIP-1:0] trip_sync
);
  typedef struct packed {
    logic [N_TRIP-1:0] s1;
    logic [N_TRIP-1:0] s2;
  } sbp_sync_t;

  sbp_sync_t q, d;

  // one stage pair per trip line
  always_comb begin
    d = q;
    for (int i = 0; i < N_TRIP; i++) begin
      d.s1[i] = trip_raw[i];
      d.s2[i] = q.s1[i];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign trip_sync = q.s2;
endmodule

// File: verilog/sbp_trip_decode.sv
// Purpose: decodes the four trip select bits into level indices
// Assumes: select bits are stable configuration
// Notes:   reserved codes report valid low and level index zero
`timescale 1ns/1ps
module sbp_trip_decode
  import sbp_pkg::*;
(
  sbp_trip_if.dec tif
);
  // reset pair in sel[3:2], interrupt pair in sel[1:0]
  always_comb begin
    tif.valid   = 1'b1;
    tif.rst_lvl = RLVL_2V2;
    tif.irq_lvl = ILVL_2V4;
    case (tif.sel)
      4'h5: begin
        tif.rst_lvl = RLVL_2V2;
        tif.irq_lvl = ILVL_2V4;
      end
      4'h6: begin
        tif.rst_lvl = RLVL_2V2;
        tif.irq_lvl = ILVL_2V6;
      end
      4'h7: begin
        tif.rst_lvl = RLVL_2V2;
        tif.irq_lvl = ILVL_3V2;
      end
      4'ha: begin
        tif.rst_lvl = RLVL_2V4;
        tif.irq_lvl = ILVL_2V6;
      end
      4'hb: begin
        tif.rst_lvl = RLVL_2V4;
        tif.irq_lvl = ILVL_3V2;
      end
      4'hf: begin
        tif.rst_lvl = RLVL_3V0;
        tif.irq_lvl = ILVL_3V2;
      end
      default: begin
        tif.valid = 1'b0;
      end
    endcase
  end
endmodule

// File: verilog/sbp_monitor.sv
// Purpose: brownout reset/interrupt/flash-protect control and power-on flags
// Assumes: reset_n is the power-on reset; comparator trips are asynchronous
// Notes:   registers sit on a plain strobe port, read data one cycle later
//          brownout flags are level-set, so a clear during a live trip is lost
//          reserved select codes keep the reset path; live register shows them
//          trips cross two flops, so cpu_reset_req, flash_write_block and irq trail a comparator by three edges, brownout_irq by four
//          event status clears by writing one, reset-source flags by zero
//
// Functional notes
// - brownout reset trip always resets the processor
// - total power-down disables all brownout detection
// - interrupt request needs brownout interrupt enable bit
// - interrupt also needs source and global enables
// - reset level from two user config bits
// - interrupt level from two config register bits
// - four-bit select code maps levels, rest reserved
// - brownout reset flag clears at reset, sets on trip
// - brownout interrupt flag clears at reset, sets on trip
// - flash protect active unless power-down bit set
// - flash trip below 2.4 V blocks program/erase
// - condition follows supply against selected level
// - power-on flag set at power-on, cleared by zero
// - power-on flag setting also sets brownout reset flag
// - power mode 00 normal, 01 idle, 10 power-down
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
module sbp_monitor
  import sbp_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic [sbp_pkg::AW-1:0] reg_addr,
  input  wire logic [sbp_pkg::DW-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [sbp_pkg::DW-1:0] reg_rdata,
  input  wire logic [sbp_pkg::DW-1:0] user_config_byte,
  input  wire logic                   cmp_reset_trip,
  input  wire logic                   cmp_irq_trip,
  input  wire logic                   cmp_flash_trip,
  output logic                        detector_en,
  output logic                        flash_detector_en,
  output logic      [1:0]             reset_level_sel,
  output logic      [1:0]             irq_level_sel,
  output logic                        cpu_reset_req,
  output logic                        brownout_irq,
  output logic                        flash_write_block,
  output logic                        irq
);
  import sbp_pkg::*;

  typedef struct packed {
    // startup state and software registers
    sbp_state_t       state;
    logic [1:0]       power_mode;
    logic             brownout_irq_enable;
    logic             brownout_int_en;
    logic             global_int_en;
    logic [1:0]       brownout_config_field;

    // sticky reset-source flags
    logic             poweron_flag;
    logic             brownout_reset_flag;
    logic             brownout_irq_flag;

    // event status and its edge memory
    logic [N_TRIP-1:0] trip_prev;
    logic [N_EVT-1:0] evt_stat;
    logic [N_EVT-1:0] evt_en;

    // registered outputs; nothing combinational reaches a pin
    logic [DW-1:0]    rdata;
    logic             det_en;
    logic             flash_det_en;
    logic [1:0]       rst_sel;
    logic [1:0]       irq_sel;
    logic             cpu_reset;
    logic             bo_irq;
    logic             flash_block;
    logic             irq;
  } sbp_regs_t;

  // q is the only state; d is its next value
  sbp_regs_t q, d;

  // trip lines, raw and synchronised
  logic [N_TRIP-1:0] trip_raw;
  logic [N_TRIP-1:0] trip_s;
  logic [N_TRIP-1:0] trip_rise;
  logic [N_EVT-1:0]  evt_set;

  // mode decode and gated conditions
  logic              total_pd;
  logic              pd_bit;
  logic              reset_trip;
  logic              irq_trip;
  logic              flash_trip;

  // register write strobes
  logic              wr_pwr;
  logic              wr_ien;
  logic              wr_cfg;
  logic              wr_rsrc;
  logic              wr_clr;
  logic              wr_ena;

  // startup pulse and read path
  logic              por_set;
  logic [DW-1:0]     rd_mux;

  // select code and decoded levels travel together
  sbp_trip_if tif ();

  // trip lines gathered for the synchroniser
  assign trip_raw[TRIP_RST]   = cmp_reset_trip;
  assign trip_raw[TRIP_IRQ]   = cmp_irq_trip;
  assign trip_raw[TRIP_FLASH] = cmp_flash_trip;

  // the analog side is free-running; never use a raw trip
  sbp_sync u_sync (
    .clk       (clk),
    .reset_n   (reset_n),
    .trip_raw  (trip_raw),
    .trip_sync (trip_s)
  );

  // select code: reset pair from user config, interrupt pair from register
  assign tif.sel = {user_config_byte[UCFG_HI_BIT],
                    user_config_byte[UCFG_LO_BIT],
                    q.brownout_config_field};

  // reserved codes are flagged, never blocked
  sbp_trip_decode u_dec (
    .tif (tif.dec)
  );

  // power mode decode
  assign total_pd = (q.power_mode == MODE_TOTAL);
  assign pd_bit   = q.power_mode[1];

  // gated trip conditions; they follow the comparators both ways
  assign reset_trip = !total_pd && trip_s[TRIP_RST];
  assign irq_trip   = !total_pd && trip_s[TRIP_IRQ];
  assign flash_trip = !pd_bit && trip_s[TRIP_FLASH];

  // rising edges feed the sticky event status
  // trip_prev resets low like the synchroniser, so no false edge
  assign trip_rise = trip_s & ~q.trip_prev;

  // power-on is taken once, in the second cycle out of reset, after one cycle in ST_RESET
  assign por_set = (q.state == ST_POWERON);

  // event sets; flash follows its own power-down gate
  always_comb begin
    evt_set            = '0;
    evt_set[EVT_RST]   = trip_rise[TRIP_RST] && !total_pd;
    evt_set[EVT_IRQ]   = trip_rise[TRIP_IRQ] && !total_pd;
    evt_set[EVT_FLASH] = trip_rise[TRIP_FLASH] && !pd_bit;
    evt_set[EVT_POR]   = por_set;
  end

  // write decode
  // writes to read-only or unmapped offsets fall through
  assign wr_pwr  = reg_wr && (reg_addr == ADR_PWR_CTRL);
  assign wr_ien  = reg_wr && (reg_addr == ADR_INT_EN0);
  assign wr_cfg  = reg_wr && (reg_addr == ADR_BO_CFG);
  assign wr_rsrc = reg_wr && (reg_addr == ADR_RST_SRC);
  assign wr_clr  = reg_wr && (reg_addr == ADR_INT_CLR);
  assign wr_ena  = reg_wr && (reg_addr == ADR_INT_ENA);

  // read mux; unmapped and write-only offsets read zero
  // the mux runs free; only a strobe lets it reach the data flops
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      ADR_PWR_CTRL: begin
        rd_mux[PWR_MODE_LSB +: 2] = q.power_mode;
        rd_mux[PWR_BOI_BIT]       = q.brownout_irq_enable;
      end
      ADR_INT_EN0: begin
        rd_mux[IEN_EBO_BIT] = q.brownout_int_en;
        rd_mux[IEN_EA_BIT]  = q.global_int_en;
      end
      ADR_BO_CFG: begin
        rd_mux[BOCFG_LSB +: 2] = q.brownout_config_field;
      end
      ADR_RST_SRC: begin
        rd_mux[RSRC_POF_BIT]  = q.poweron_flag;
        rd_mux[RSRC_BOF_BIT]  = q.brownout_reset_flag;
        rd_mux[RSRC_BROWNOUT_IRQ_FLAG_BIT] = q.brownout_irq_flag;
      end
      // status and enable share one layout
      ADR_INT_STAT: begin
        rd_mux[N_EVT-1:0] = q.evt_stat;
      end
      ADR_INT_ENA: begin
        rd_mux[N_EVT-1:0] = q.evt_en;
      end
      // live view: trips, code valid, decoded levels
      ADR_LIVE: begin
        rd_mux[N_TRIP-1:0] = trip_s;
        rd_mux[3]          = tif.valid;
        rd_mux[5:4]        = tif.rst_lvl;
        rd_mux[7:6]        = tif.irq_lvl;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // next-state logic for the whole block
  // later assignments win, so clears come before sets
  always_comb begin
    d = q;

    // startup sequence: one power-on cycle, then run
    case (q.state)
      ST_RESET: begin
        d.state = ST_POWERON;
      end
      ST_POWERON: begin
        d.state = ST_RUN;
      end
      ST_RUN: begin
        d.state = ST_RUN;
      end
      default: begin
        d.state = ST_RESET;
      end
    endcase

    // power control: mode field and interrupt enable
    if (wr_pwr) begin
      d.power_mode          = reg_wdata[PWR_MODE_LSB +: 2];
      d.brownout_irq_enable = reg_wdata[PWR_BOI_BIT];
    end

    // interrupt enable register
    if (wr_ien) begin
      d.brownout_int_en = reg_wdata[IEN_EBO_BIT];
      d.global_int_en   = reg_wdata[IEN_EA_BIT];
    end

    // interrupt trip level select
    if (wr_cfg) begin
      d.brownout_config_field = reg_wdata[BOCFG_LSB +: 2];
    end

    // reset source flags: a written 0 clears, a 1 is ignored
    if (wr_rsrc && !reg_wdata[RSRC_POF_BIT]) begin
      d.poweron_flag = 1'b0;
    end
    if (wr_rsrc && !reg_wdata[RSRC_BOF_BIT]) begin
      d.brownout_reset_flag = 1'b0;
    end
    if (wr_rsrc && !reg_wdata[RSRC_BROWNOUT_IRQ_FLAG_BIT]) begin
      d.brownout_irq_flag = 1'b0;
    end

    // sets come after clears so a same-cycle event is not lost
    if (por_set) begin
      d.poweron_flag        = 1'b1;
      d.brownout_reset_flag = 1'b1;
    end
    if (reset_trip) begin
      d.brownout_reset_flag = 1'b1;
    end
    if (irq_trip) begin
      d.brownout_irq_flag = 1'b1;
    end

    // event status: write-one clear, set wins
    d.trip_prev = trip_s;
    if (wr_ena) begin
      d.evt_en = reg_wdata[N_EVT-1:0];
    end
    if (wr_clr) begin
      d.evt_stat = q.evt_stat & ~reg_wdata[N_EVT-1:0];
    end
    d.evt_stat = d.evt_stat | evt_set;

    // analog controls; detectors off in total power-down
    d.det_en       = !total_pd;
    d.flash_det_en = !pd_bit;
    d.rst_sel      = tif.sel[3:2];
    d.irq_sel      = tif.sel[1:0];

    // reset has no software gate at all, only the mode
    d.cpu_reset = reset_trip;

    // processor interrupt follows the full enable chain
    d.bo_irq = !total_pd &&
               q.brownout_irq_enable &&
               q.brownout_int_en &&
               q.global_int_en &&
               q.brownout_irq_flag;

    // flash guard has no software gate of its own, only the power-down bit
    d.flash_block = flash_trip;

    // combined level interrupt of the event status
    d.irq = |(d.evt_stat & q.evt_en);

    // read data stands only in the cycle after the strobe
    d.rdata = reg_rd ? rd_mux : '0;
  end

  // single register bank for all state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // fields below restate their zero resets, except the two detector enables
      q                       <= '0;
      q.state                 <= ST_RESET;
      q.power_mode            <= MODE_RST;
      q.brownout_config_field <= BOCFG_RST;
      q.evt_en                <= EVT_EN_RST;
      // detectors come up enabled, as in normal mode
      q.det_en                <= 1'b1;
      q.flash_det_en          <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  // register port
  assign reg_rdata         = q.rdata;

  // analog controls
  assign detector_en       = q.det_en;
  assign flash_detector_en = q.flash_det_en;
  assign reset_level_sel   = q.rst_sel;
  assign irq_level_sel     = q.irq_sel;

  // processor-facing requests
  assign cpu_reset_req     = q.cpu_reset;
  assign brownout_irq      = q.bo_irq;
  assign flash_write_block = q.flash_block;
  assign irq               = q.irq;
endmodule

// File: testbench/sbp_cmp_model.sv
// Purpose: behavioural supply comparators facing the monitor
// Assumes: supply given in tenths of a volt; trips are plain levels
// Notes:   reserved select codes fall back to the lowest ladder taps
`timescale 1ns/1ps
module sbp_cmp_model (
  input  wire logic [7:0] supply_dv,
  input  wire logic       detector_en,
  input  wire logic       flash_detector_en,
  input  wire logic [1:0] reset_level_sel,
  input  wire logic [1:0] irq_level_sel,
  output logic            cmp_reset_trip,
  output logic            cmp_irq_trip,
  output logic            cmp_flash_trip
);
  logic [15:0] lv;
  // ladder taps: reset level high byte, interrupt level low byte
  always_comb begin
    case ({reset_level_sel, irq_level_sel})
      4'h6:    lv = {8'h16, 8'h1a};
      4'h7:    lv = {8'h16, 8'h20};
      4'ha:    lv = {8'h18, 8'h1a};
      4'hb:    lv = {8'h18, 8'h20};
      4'hf:    lv = {8'h1e, 8'h20};
      default: lv = {8'h16, 8'h18};
    endcase
  end
  // a disabled comparator reads as no trip, like the powered-down circuit
  assign cmp_reset_trip = detector_en && (supply_dv < lv[15:8]);
  assign cmp_irq_trip   = detector_en && (supply_dv < lv[7:0]);
  assign cmp_flash_trip = flash_detector_en && (supply_dv < 8'h18);
endmodule

// File: testbench/sbp_monitor_chk.sv
// Purpose: temporal checks on the monitor ports
// Assumes: one clock, async active-low reset
// Notes:   trip paths take three edges from comparator to output, four to brownout_irq
`timescale 1ns/1ps
module sbp_monitor_chk
  import sbp_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic [sbp_pkg::AW-1:0] reg_addr,
  input wire logic [sbp_pkg::DW-1:0] reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [sbp_pkg::DW-1:0] reg_rdata,
  input wire logic [sbp_pkg::DW-1:0] user_config_byte,
  input wire logic                   cmp_reset_trip,
  input wire logic                   cmp_irq_trip,
  input wire logic                   cmp_flash_trip,
  input wire logic                   detector_en,
  input wire logic                   flash_detector_en,
  input wire logic [1:0]             reset_level_sel,
  input wire logic [1:0]             irq_level_sel,
  input wire logic                   cpu_reset_req,
  input wire logic                   brownout_irq,
  input wire logic                   flash_write_block,
  input wire logic                   irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_total_pd_quiet: assert property (
    !detector_en |-> !cpu_reset_req && !brownout_irq) else $error("brownout out while off");
  a_reset_on_trip: assert property (
    (cmp_reset_trip && detector_en) [*3] ##1 detector_en |-> cpu_reset_req)
    else $error("reset trip not forwarded");
  a_reset_clears: assert property (
    (!cmp_reset_trip) [*3] |=> !cpu_reset_req) else $error("reset stays after recovery");
  a_flash_blocks: assert property (
    (cmp_flash_trip && flash_detector_en) [*3] ##1 flash_detector_en |-> flash_write_block)
    else $error("flash not blocked");
  a_flash_off_pd: assert property (
    !flash_detector_en |-> !flash_write_block) else $error("flash block in power-down");
  a_rst_sel_cfg: assert property (
    $stable(user_config_byte) [*3] |->
    reset_level_sel == {user_config_byte[5], user_config_byte[3]})
    else $error("reset level select wrong");
  a_irq_sel_hold: assert property (
    !reg_wr && !$past(reg_wr) |=> $stable(irq_level_sel)) else $error("irq level moved");
  a_trip_synced: assert property (
    $rose(cmp_reset_trip) && !cpu_reset_req |=> !cpu_reset_req)
    else $error("raw trip used unsynchronised");
  a_boirq_sticky: assert property (
    brownout_irq && !reg_wr && !$past(reg_wr) |=> brownout_irq)
    else $error("brownout irq dropped alone");
  c_reset: cover property (cpu_reset_req);
  c_boirq: cover property (brownout_irq && irq);
  c_flash: cover property (flash_write_block);
endmodule
bind sbp_monitor sbp_monitor_chk sbp_monitor_chk_i (.clk(clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .user_config_byte(user_config_byte),
  .cmp_reset_trip(cmp_reset_trip), .cmp_irq_trip(cmp_irq_trip),
  .cmp_flash_trip(cmp_flash_trip), .detector_en(detector_en),
  .flash_detector_en(flash_detector_en), .reset_level_sel(reset_level_sel),
  .irq_level_sel(irq_level_sel), .cpu_reset_req(cpu_reset_req),
  .brownout_irq(brownout_irq), .flash_write_block(flash_write_block), .irq(irq));

// File: testbench/sbp_monitor_tb.sv
// Purpose: self-checking bench for the brownout / power-on monitor
// Assumes: comparator model on the far side, supply in tenths of a volt
// Notes:   random supply and codes from a fixed lfsr seed
`timescale 1ns/1ps
module sbp_monitor_tb;
  import sbp_pkg::*;
  logic          clk, reset_n, reg_wr, reg_rd, detector_en, flash_detector_en;
  logic          cpu_reset_req, brownout_irq, flash_write_block, irq;
  logic          cmp_reset_trip, cmp_irq_trip, cmp_flash_trip;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, user_config_byte;
  logic [7:0]    supply_dv, lfsr;
  logic [1:0]    reset_level_sel, irq_level_sel;
  logic [3:0]    code;
  logic [3:0]    codes [6] = '{4'h5, 4'h6, 4'h7, 4'ha, 4'hb, 4'hf};
  int            err_total, num_checks;
  sbp_monitor sbp_monitor_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .user_config_byte(user_config_byte), .cmp_reset_trip(cmp_reset_trip),
    .cmp_irq_trip(cmp_irq_trip), .cmp_flash_trip(cmp_flash_trip),
    .detector_en(detector_en), .flash_detector_en(flash_detector_en),
    .reset_level_sel(reset_level_sel), .irq_level_sel(irq_level_sel),
    .cpu_reset_req(cpu_reset_req), .brownout_irq(brownout_irq),
    .flash_write_block(flash_write_block), .irq(irq));
  sbp_cmp_model sbp_cmp_model_i (.supply_dv(supply_dv), .detector_en(detector_en),
    .flash_detector_en(flash_detector_en), .reset_level_sel(reset_level_sel),
    .irq_level_sel(irq_level_sel), .cmp_reset_trip(cmp_reset_trip),
    .cmp_irq_trip(cmp_irq_trip), .cmp_flash_trip(cmp_flash_trip));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] nxt(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // live register with the supply above every level: valid, reset idx, irq idx
  function automatic logic [7:0] exp_live(logic [3:0] c);
    case (c)
      4'h5: return 8'h08;
      4'h6: return 8'h48;
      4'h7: return 8'h88;
      4'ha: return 8'h58;
      4'hb: return 8'h98;
      4'hf: return 8'ha8;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] rst_lvl(logic [1:0] p);
    return (p == 2'h1) ? 8'h16 : (p == 2'h2) ? 8'h18 : 8'h1e;
  endfunction
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // settle point just after an edge
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(string nm, logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, reg_rdata, exp);
  endtask
  task automatic cfg(logic [3:0] c);
    @(posedge clk);
    user_config_byte <= {2'h0, c[3], 1'b0, c[2], 3'h0};
    wr(ADR_BO_CFG, {6'h0, c[1:0]});
  endtask
  task automatic sup(logic [7:0] v);
    @(posedge clk);
    supply_dv <= v;
    tick(6);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog well beyond the expected few hundred cycles
  initial begin
    #500000;
    err_total++;
    stop_test();
  end
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    user_config_byte = 8'h08;
    supply_dv = 8'h28;
    lfsr = 8'h60;
    err_total = 0;
    num_checks = 0;
    tick(10);
    chk("det_en_rst", detector_en, 1'b1);
    @(posedge clk);
    reset_n <= 1'b1;
    tick(3);
    rd("rst_src_por", ADR_RST_SRC, 8'h30);
    rd("stat_por", ADR_INT_STAT, 8'h08);
    wr(ADR_RST_SRC, 8'hff);
    rd("rst_src_w1", ADR_RST_SRC, 8'h30);
    wr(ADR_RST_SRC, 8'h00);
    rd("rst_src_clr", ADR_RST_SRC, 8'h00);
    rd("unmapped", 8'h20, 8'h00);
    $display("test power-on done");
    for (int c = 0; c < 16; c++) begin
      cfg(c[3:0]);
      tick(3);
      chk("rst_sel", reset_level_sel, c[3:2]);
      chk("irq_sel", irq_level_sel, c[1:0]);
      rd("live", ADR_LIVE, exp_live(c[3:0]));
    end
    $display("test trip codes done");
    cfg(4'h5);
    rd("cfg_rb", ADR_BO_CFG, 8'h01);
    sup(8'h17);
    chk("bo_irq_off", brownout_irq, 1'b0);
    chk("flash_blk", flash_write_block, 1'b1);
    chk("rst_req_above", cpu_reset_req, 1'b0);
    rd("brownout_irq_flag", ADR_RST_SRC, 8'h40);
    for (int k = 0; k < 8; k++) begin
      wr(ADR_PWR_CTRL, {3'h0, k[2], 4'h0});
      wr(ADR_INT_EN0, {k[1], 1'b0, k[0], 5'h0});
      tick(3);
      chk("bo_irq_gate", brownout_irq, &k[2:0]);
    end
    rd("ien_rb", ADR_INT_EN0, 8'ha0);
    sup(8'h15);
    for (int m = 0; m < 4; m++) begin
      wr(ADR_PWR_CTRL, 8'h10 | m[7:0]);
      tick(5);
      chk("rst_req", cpu_reset_req, m != 3);
      chk("bo_irq", brownout_irq, m != 3);
      chk("det_en", detector_en, m != 3);
      chk("flash_en", flash_detector_en, !m[1]);
      chk("flash_blk_m", flash_write_block, !m[1]);
    end
    wr(ADR_PWR_CTRL, 8'h10);
    rd("pwr_rb", ADR_PWR_CTRL, 8'h10);
    sup(8'h28);
    chk("rst_req_lo", cpu_reset_req, 1'b0);
    rd("flags_sticky", ADR_RST_SRC, 8'h60);
    wr(ADR_RST_SRC, 8'h00);
    tick(2);
    chk("bo_irq_clr", brownout_irq, 1'b0);
    $display("test brownout done");
    wr(ADR_INT_CLR, 8'h0f);
    wr(ADR_INT_ENA, 8'h01);
    tick(2);
    chk("irq_idle", irq, 1'b0);
    sup(8'h15);
    chk("irq_set", irq, 1'b1);
    rd("stat", ADR_INT_STAT, 8'h07);
    wr(ADR_INT_ENA, 8'h00);
    tick(2);
    chk("irq_mask", irq, 1'b0);
    wr(ADR_INT_ENA, 8'h04);
    tick(2);
    chk("irq_flash", irq, 1'b1);
    rd("ena_rb", ADR_INT_ENA, 8'h04);
    sup(8'h28);
    // status is read-only, only the clear register may drop it
    wr(ADR_INT_STAT, 8'h00);
    rd("stat_ro", ADR_INT_STAT, 8'h07);
    wr(ADR_INT_CLR, 8'h07);
    tick(2);
    chk("irq_clr", irq, 1'b0);
    rd("clr_wo", ADR_INT_CLR, 8'h00);
    $display("test interrupt done");
    for (int i = 0; i < 12; i++) begin
      lfsr = nxt(lfsr);
      code = codes[lfsr[6:4] % 6];
      cfg(code);
      sup(8'h14 + {4'h0, lfsr[3:0]});
      chk("rnd_rst", cpu_reset_req, supply_dv < rst_lvl(code[3:2]));
      chk("rnd_flash", flash_write_block, supply_dv < 8'h18);
    end
    $display("test random supply done");
    stop_test();
  end
endmodule
